//--- rtl/asc_pkg.sv
// Constants for the converter sequencing control block
package asc_pkg;

   // Register byte addresses
   localparam logic [7:0] OFS_CTRL_A    = 8'h00;
   localparam logic [7:0] OFS_CTRL_B    = 8'h04;
   localparam logic [7:0] OFS_RES_LOW   = 8'h08;
   localparam logic [7:0] OFS_RES_HIGH  = 8'h0C;
   localparam logic [7:0] OFS_PIN_SHARE = 8'h10;
   localparam logic [7:0] OFS_PORT_DIR  = 8'h14;
   localparam logic [7:0] OFS_PULL_HIGH = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

   // converter_control_a fields
   localparam int BIT_START   = 7;
   localparam int BIT_BUSY    = 6;
   localparam int BIT_POWER   = 5;
   localparam int BIT_JUSTIFY = 4;
   localparam int POS_CHAN    = 0;
   // converter_control_b fields
   localparam int POS_INSRC   = 5;
   localparam int POS_REFSEL  = 3;
   localparam int POS_CKDIV   = 0;
   // pin_share_select_a: bits 5:0 analog inputs, bit 6 reference pin function
   localparam int BIT_VREF_PIN = 6;
   // Interrupt status bit for conversion complete
   localparam int BIT_IRQ_DONE = 0;

   // Reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_PINS   = 8'h00;

   // Reference and channel codes
   localparam logic [1:0] REF_AVDD    = 2'h1;
   localparam logic [1:0] REF_DAC     = 2'h2;
   localparam logic [2:0] INS_EXT_LO  = 3'h0;
   localparam logic [2:0] INS_EXT_HI  = 3'h7;
   localparam logic [3:0] CHAN_LAST   = 4'h5;
   localparam int         NUM_PINS    = 6;

   // Conversion timing in conversion clocks
   localparam logic [3:0] SAMPLE_CLKS = 4'h4;
   localparam logic [3:0] CONV_CLKS   = 4'hC;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_CONVERT
   } asc_seq_state_t;

endpackage : asc_pkg

//--- rtl/asc_conv_if.sv
// Signals between the control top, prescaler and sequencer
`timescale 1ns/10ps
interface asc_conv_if;
   logic [2:0] div_sel;
   logic       power;
   logic       tick;
   logic       start;
   logic       busy;
   logic       sample;
   logic       convert;
   logic       done;

   modport ctl (output div_sel, power, start, input tick, busy, sample, convert, done);
   modport div (input div_sel, power, output tick);
   modport seq (input power, tick, start, output busy, sample, convert, done);
endinterface : asc_conv_if

//--- rtl/asc_clkdiv.sv
// Conversion clock prescaler: one-cycle enable every 2**div_sel cycles
`timescale 1ns/10ps
module asc_clkdiv (
   input  wire logic CORE_CLK,
   input  wire logic SYS_RST,
   asc_conv_if.div   cv
);
   logic [6:0] cnt_r;
   logic [6:0] mask;

   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      logic [7:0] m;
      m = (8'h01 << sel) - 8'h01;
      return m[6:0];
   endfunction : div_mask

   assign mask    = div_mask(cv.div_sel);
   assign cv.tick = cv.power && ((cnt_r & mask) == mask);

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt_r <= 7'h00;
      end else if (!cv.power) begin
         cnt_r <= 7'h00;
      end else begin
         cnt_r <= cnt_r + 7'h01;
      end
   end

   tick_div1_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (cv.power && cv.div_sel == 3'h0) |-> cv.tick) else $error("undivided tick missing");
   tick_div8_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (cv.tick && cv.div_sel == 3'h3 && cv.power) ##1 (cv.div_sel == 3'h3 && cv.power) [*7]
      |-> !$past(cv.tick) ##0 1'b1) else $error("divide by eight tick spacing wrong");
   tick_off_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !cv.power |-> !cv.tick) else $error("tick while unpowered");
endmodule : asc_clkdiv

//--- rtl/asc_seq.sv
// Conversion sequencer: sampling then conversion phase, counted in conversion clocks
`timescale 1ns/10ps
module asc_seq (
   input  wire logic CORE_CLK,
   input  wire logic SYS_RST,
   asc_conv_if.seq   cv
);
   asc_pkg::asc_seq_state_t state_r;
   logic [3:0]              cnt_r;
   logic                    done_r;

   assign cv.busy    = (state_r != asc_pkg::SEQ_IDLE);
   assign cv.sample  = (state_r == asc_pkg::SEQ_SAMPLE);
   assign cv.convert = (state_r == asc_pkg::SEQ_CONVERT);
   assign cv.done    = done_r;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_r <= asc_pkg::SEQ_IDLE;
         cnt_r   <= 4'h0;
         done_r  <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (!cv.power) begin
            state_r <= asc_pkg::SEQ_IDLE; // Power loss aborts without completion
            cnt_r   <= 4'h0;
         end else begin
            case (state_r)
               asc_pkg::SEQ_IDLE: begin
                  if (cv.start) begin
                     state_r <= asc_pkg::SEQ_SAMPLE;
                     cnt_r   <= 4'h0;
                  end
               end
               asc_pkg::SEQ_SAMPLE: begin
                  if (cv.tick) begin
                     if (cnt_r == asc_pkg::SAMPLE_CLKS - 4'h1) begin
                        state_r <= asc_pkg::SEQ_CONVERT;
                        cnt_r   <= 4'h0;
                     end else begin
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               asc_pkg::SEQ_CONVERT: begin
                  if (cv.tick) begin
                     if (cnt_r == asc_pkg::CONV_CLKS - 4'h1) begin
                        state_r <= asc_pkg::SEQ_IDLE;
                        done_r  <= 1'b1;
                        cnt_r   <= 4'h0;
                     end else begin
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               default: begin
                  state_r <= asc_pkg::SEQ_IDLE;
               end
            endcase
         end
      end
   end

   sample_end_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (cv.sample && cv.tick && cv.power && cnt_r == 4'h3) |=> cv.convert) else $error("sampling not 4 clocks");
   convert_end_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (cv.convert && cv.tick && cv.power && cnt_r == 4'hB) |=> (cv.done && !cv.busy)) else $error("conversion not 12 clocks");
   busy_hold_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (cv.busy && cv.power && !cv.tick) |=> cv.busy && $stable(cnt_r) && $stable(state_r)) else $error("start disturbed conversion");
endmodule : asc_seq

//--- rtl/asc_top.sv
// Converter sequencing control: AHB-Lite registers, mux and reference selects, pin share
//
// Functional notes
// - Conversion clock is system clock over 2**select
// - Converter powered only while power bit set
// - Reference: 01 supply, 10 DAC, else pin
// - Analog pin disables other functions and pull-high
// - Analog selection overrides port direction
// - External source: codes 0-5 pick pins, else none
// - Source codes 1-6 route internal signals
// - Sample four clocks, then convert twelve
// - Start bit high-then-low begins conversion
// - Busy during conversion, completion raises interrupt flag
// - Justify bit selects left or right result
// - Results kept while converter disabled
`timescale 1ns/10ps
module asc_top (
   input  wire logic        CORE_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic             IRQ,
   input  wire logic [11:0] ADC_RESULT,
   output logic             ADC_POWER_ON,
   output logic             CONV_CLK_TICK,
   output logic             SAMPLE_EN,
   output logic             CONVERT_EN,
   output logic             REF_EXT_SEL,
   output logic             REF_AVDD_SEL,
   output logic             REF_DAC_SEL,
   output logic             VREF_PIN_EN,
   output logic [5:0]       EXT_CH_EN,
   output logic [5:0]       INT_SRC_EN,
   output logic [5:0]       PIN_ANALOG_EN,
   output logic [5:0]       PIN_DIGITAL_EN,
   output logic [5:0]       PIN_OUT_EN,
   output logic [5:0]       PIN_PULL_EN
);

   asc_conv_if cv ();

   // Register state
   logic [7:0]  ctrl_a_r;
   logic [7:0]  ctrl_b_r;
   logic [6:0]  pin_share_r;
   logic [5:0]  port_dir_r;
   logic [5:0]  pull_high_r;
   logic [11:0] result_r;
   logic        irq_stat_r;
   logic        irq_mask_r;

   // AHB-Lite data phase bookkeeping
   logic        dp_write_r;
   logic        dp_read_r;
   logic [7:0]  dp_addr_r;
   logic        ap_valid;
   logic [7:0]  ap_addr;
   logic        wr_ctrl_a;
   logic        rd_irq_stat;
   logic [31:0] rd_data;

   // Decoded fields
   logic        power_on;
   logic        justify_right;
   logic [3:0]  chan_sel;
   logic [2:0]  ins_sel;
   logic [1:0]  ref_sel;
   logic        start_seq;
   logic        ext_source;

   assign power_on      = ctrl_a_r[asc_pkg::BIT_POWER];
   assign justify_right = ctrl_a_r[asc_pkg::BIT_JUSTIFY];
   assign chan_sel      = ctrl_a_r[asc_pkg::POS_CHAN +: 4];
   assign ins_sel       = ctrl_b_r[asc_pkg::POS_INSRC +: 3];
   assign ref_sel       = ctrl_b_r[asc_pkg::POS_REFSEL +: 2];

   // Bus slave: zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign ap_valid  = HSEL && HTRANS[1] && HREADY;
   assign ap_addr   = {HADDR[7:2], 2'b00};

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dp_write_r <= 1'b0;
         dp_read_r  <= 1'b0;
         dp_addr_r  <= 8'h00;
      end else if (HREADY) begin
         dp_write_r <= ap_valid && HWRITE;
         dp_read_r  <= ap_valid && !HWRITE;
         dp_addr_r  <= ap_addr;
      end
   end

   assign wr_ctrl_a   = dp_write_r && (dp_addr_r == asc_pkg::OFS_CTRL_A);
   assign rd_irq_stat = dp_read_r && (dp_addr_r == asc_pkg::OFS_IRQ_STAT);

   // Start fires when the start bit is written low after being high
   assign start_seq = wr_ctrl_a && ctrl_a_r[asc_pkg::BIT_START] && !HWDATA[asc_pkg::BIT_START];

   // converter_control_a: busy bit is read only and never stored
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_a_r <= asc_pkg::RST_CTRL_A;
      end else if (wr_ctrl_a) begin
         ctrl_a_r <= HWDATA[7:0] & ~(8'h01 << asc_pkg::BIT_BUSY);
      end
   end

   // converter_control_b
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_b_r <= asc_pkg::RST_CTRL_B;
      end else if (dp_write_r && dp_addr_r == asc_pkg::OFS_CTRL_B) begin
         ctrl_b_r <= HWDATA[7:0];
      end
   end

   // Pin share, port direction and pull-high controls
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_share_r <= asc_pkg::RST_PINS[6:0];
         port_dir_r  <= asc_pkg::RST_PINS[5:0];
         pull_high_r <= asc_pkg::RST_PINS[5:0];
      end else if (dp_write_r) begin
         if (dp_addr_r == asc_pkg::OFS_PIN_SHARE) begin
            pin_share_r <= HWDATA[6:0];
         end
         if (dp_addr_r == asc_pkg::OFS_PORT_DIR) begin
            port_dir_r <= HWDATA[5:0];
         end
         if (dp_addr_r == asc_pkg::OFS_PULL_HIGH) begin
            pull_high_r <= HWDATA[5:0];
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_mask_r <= 1'b0;
      end else if (dp_write_r && dp_addr_r == asc_pkg::OFS_IRQ_MASK) begin
         irq_mask_r <= HWDATA[asc_pkg::BIT_IRQ_DONE];
      end
   end

   // Completion flag: set wins over the clear that a status read performs
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_stat_r <= 1'b0;
      end else if (cv.done) begin
         irq_stat_r <= 1'b1;
      end else if (rd_irq_stat) begin
         irq_stat_r <= 1'b0;
      end
   end

   assign IRQ = irq_stat_r && irq_mask_r;

   // Result capture only at completion; a powered-down converter never completes
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         result_r <= 12'h000;
      end else if (cv.done && power_on) begin
         result_r <= ADC_RESULT;
      end
   end

   // Read mux, registered into the data phase
   always_comb begin
      rd_data = 32'h0000_0000;
      case (ap_addr)
         asc_pkg::OFS_CTRL_A: begin
            rd_data[7:0] = ctrl_a_r;
            rd_data[asc_pkg::BIT_BUSY] = cv.busy;
         end
         asc_pkg::OFS_CTRL_B: begin
            rd_data[7:0] = ctrl_b_r;
         end
         asc_pkg::OFS_RES_LOW: begin
            rd_data[7:0] = justify_right ? result_r[7:0] : {result_r[3:0], 4'h0};
         end
         asc_pkg::OFS_RES_HIGH: begin
            rd_data[7:0] = justify_right ? {4'h0, result_r[11:8]} : result_r[11:4];
         end
         asc_pkg::OFS_PIN_SHARE: begin
            rd_data[6:0] = pin_share_r;
         end
         asc_pkg::OFS_PORT_DIR: begin
            rd_data[5:0] = port_dir_r;
         end
         asc_pkg::OFS_PULL_HIGH: begin
            rd_data[5:0] = pull_high_r;
         end
         asc_pkg::OFS_IRQ_STAT: begin
            rd_data[asc_pkg::BIT_IRQ_DONE] = irq_stat_r;
         end
         asc_pkg::OFS_IRQ_MASK: begin
            rd_data[asc_pkg::BIT_IRQ_DONE] = irq_mask_r;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (ap_valid && !HWRITE) begin
         HRDATA <= rd_data;
      end
   end

   // Prescaler and sequencer
   assign cv.div_sel = ctrl_b_r[asc_pkg::POS_CKDIV +: 3];
   assign cv.power   = power_on;
   assign cv.start   = start_seq && !cv.busy;

   asc_clkdiv u_clkdiv (
      .CORE_CLK (CORE_CLK),
      .SYS_RST  (SYS_RST),
      .cv       (cv.div)
   );

   asc_seq u_seq (
      .CORE_CLK (CORE_CLK),
      .SYS_RST  (SYS_RST),
      .cv       (cv.seq)
   );

   // Analog core controls
   assign ADC_POWER_ON  = power_on;
   assign CONV_CLK_TICK = cv.tick;
   assign SAMPLE_EN     = cv.sample;
   assign CONVERT_EN    = cv.convert;

   assign REF_AVDD_SEL = (ref_sel == asc_pkg::REF_AVDD);
   assign REF_DAC_SEL  = (ref_sel == asc_pkg::REF_DAC);
   assign REF_EXT_SEL  = !REF_AVDD_SEL && !REF_DAC_SEL;
   assign VREF_PIN_EN  = pin_share_r[asc_pkg::BIT_VREF_PIN];

   // Input multiplexer
   assign ext_source = (ins_sel == asc_pkg::INS_EXT_LO) || (ins_sel == asc_pkg::INS_EXT_HI);

   always_comb begin
      EXT_CH_EN = 6'h00;
      if (ext_source && chan_sel <= asc_pkg::CHAN_LAST) begin
         EXT_CH_EN = 6'h01 << chan_sel;
      end
   end

   always_comb begin
      INT_SRC_EN = 6'h00;
      if (!ext_source) begin
         INT_SRC_EN = 6'h01 << (ins_sel - 3'h1);
      end
   end

   // Pin share: analog selection wins over digital function, direction and pull-high
   assign PIN_ANALOG_EN  = pin_share_r[5:0];
   assign PIN_DIGITAL_EN = ~pin_share_r[5:0];
   assign PIN_PULL_EN    = pull_high_r & ~pin_share_r[5:0];
   assign PIN_OUT_EN     = port_dir_r & ~pin_share_r[5:0];

   irq_set_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      cv.done |=> irq_stat_r) else $error("completion did not set flag");
   irq_clear_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (rd_irq_stat && !cv.done) |=> !irq_stat_r) else $error("status read did not clear");
   start_busy_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (start_seq && !cv.busy && power_on) |=> cv.busy ##1 cv.busy) else $error("start did not raise busy");
   result_hold_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !power_on |=> $stable(result_r)) else $error("result changed while disabled");
   ref_select_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ref_sel == 2'h0 || ref_sel == 2'h3) |-> (REF_EXT_SEL && !REF_AVDD_SEL && !REF_DAC_SEL))
      else $error("external reference not chosen");
   ext_channel_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ext_source && chan_sel > 4'h5) |-> (EXT_CH_EN == 6'h00 && INT_SRC_EN == 6'h00))
      else $error("parked channel connected");
   int_source_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ins_sel == 3'h4) |-> (INT_SRC_EN == 6'h08 && EXT_CH_EN == 6'h00)) else $error("DAC source not routed");
   pin_override_a : assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(pin_share_r[0]) |-> (!PIN_PULL_EN[0] && !PIN_OUT_EN[0] && !PIN_DIGITAL_EN[0]))
      else $error("analog pin kept digital setup");
endmodule : asc_top

//--- tb/asc_top_tb.sv
// Self-checking testbench for the converter sequencing control block
`timescale 1ns/10ps
module asc_top_tb;
   logic        core_clk = 1'b0;
   logic        sys_rst  = 1'b1;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [31:0] hwdata   = 32'h0;
   logic [11:0] adc_res  = 12'h000;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, irq, pwr, tick, samp, conv;
   wire         r_ext, r_avdd, r_dac, vref_en;
   wire  [5:0]  ext_ch, int_src, p_ana, p_dig, p_oe, p_pull;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0, last_tk = 0, gap = 0, n_samp = 0, n_conv = 0;
   logic [31:0] v;

   always #10 core_clk = ~core_clk;

   asc_top asc_top_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq), .ADC_RESULT(adc_res), .ADC_POWER_ON(pwr),
      .CONV_CLK_TICK(tick), .SAMPLE_EN(samp), .CONVERT_EN(conv), .REF_EXT_SEL(r_ext), .REF_AVDD_SEL(r_avdd),
      .REF_DAC_SEL(r_dac), .VREF_PIN_EN(vref_en), .EXT_CH_EN(ext_ch), .INT_SRC_EN(int_src),
      .PIN_ANALOG_EN(p_ana), .PIN_DIGITAL_EN(p_dig), .PIN_OUT_EN(p_oe), .PIN_PULL_EN(p_pull));

   // Counts conversion clocks per phase and the spacing between them
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (tick === 1'b1) begin
         gap = cyc - last_tk;
         last_tk = cyc;
         if (samp === 1'b1) n_samp = n_samp + 1;
         if (conv === 1'b1) n_conv = n_conv + 1;
      end
   end

   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task ahb_xfer(input logic [7:0] a, input logic wr, input logic [7:0] d, output logic [31:0] rd);
      @(posedge core_clk);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb_xfer

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] dummy;
      ahb_xfer(a, 1'b1, d, dummy);
   endtask : wr

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      ahb_xfer(a, 1'b0, 8'h00, v);
      check(nm, exp, v);
   endtask : rd_chk

   function automatic logic [15:0] fmt(input logic j, input logic [11:0] r);
      return j ? {4'h0, r} : {r, 4'h0};
   endfunction : fmt

   task finish_test;
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // One full conversion at divider code d; odd codes use right justify and an unmasked interrupt
   task run_conv(input logic [2:0] d);
      logic        j;
      logic [11:0] r;
      logic [15:0] e;
      int          k;
      j = d[0];
      r = 12'hA53 ^ {d, 9'h0A5};
      e = fmt(j, r);
      adc_res <= r;
      wr(asc_pkg::OFS_IRQ_MASK, {7'h0, j});
      wr(asc_pkg::OFS_CTRL_B, {5'h0, d});
      wr(asc_pkg::OFS_CTRL_A, {3'h1, j, 4'h0});
      repeat (4) @(posedge core_clk);
      wr(asc_pkg::OFS_CTRL_A, {3'h5, j, 4'h0});
      n_samp = 0;
      n_conv = 0;
      wr(asc_pkg::OFS_CTRL_A, {3'h1, j, 4'h0});
      rd_chk("busy set", asc_pkg::OFS_CTRL_A, {24'h0, 3'h3, j, 4'h0});
      wr(asc_pkg::OFS_CTRL_A, {3'h5, j, 4'h0});
      wr(asc_pkg::OFS_CTRL_A, {3'h1, j, 4'h0});
      for (k = 0; k < 3000; k++) begin
         ahb_xfer(asc_pkg::OFS_CTRL_A, 1'b0, 8'h00, v);
         if (v[asc_pkg::BIT_BUSY] === 1'b0) break;
      end
      check("busy clear", {24'h0, 3'h1, j, 4'h0}, v);
      check("sample clocks", 32'd4, n_samp);
      check("convert clocks", 32'd12, n_conv);
      check("tick spacing", 32'd1 << d, gap);
      check("irq level", {31'h0, j}, irq);
      rd_chk("status set", asc_pkg::OFS_IRQ_STAT, 32'h1);
      rd_chk("status clear", asc_pkg::OFS_IRQ_STAT, 32'h0);
      #1 check("irq after clear", 32'h0, irq);
      rd_chk("result low", asc_pkg::OFS_RES_LOW, {24'h0, e[7:0]});
      rd_chk("result high", asc_pkg::OFS_RES_HIGH, {24'h0, e[15:8]});
   endtask : run_conv

   initial begin
      int          s, c, k;
      logic [5:0]  ee, ei;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk("ctrl a reset", asc_pkg::OFS_CTRL_A, 32'h0);
      rd_chk("ctrl b reset", asc_pkg::OFS_CTRL_B, 32'h0);
      check("ref reset", 32'h4, {r_ext, r_avdd, r_dac});
      check("chan reset", 32'h01, ext_ch);
      check("digital reset", 32'h3F, p_dig);
      check("okay resp", 32'h0, hresp);
      wr(8'h3C, 8'hFF);
      rd_chk("unmapped", 8'h3C, 32'h0);
      wr(asc_pkg::OFS_CTRL_A, 8'h4F);
      rd_chk("busy read only", asc_pkg::OFS_CTRL_A, 32'h0F);
      $display("Test reset done");

      for (k = 0; k < 4; k++) begin
         wr(asc_pkg::OFS_CTRL_B, {3'h0, 2'(k), 3'h0});
         #1 check("ref select", (k == 1) ? 32'h2 : (k == 2) ? 32'h1 : 32'h4, {r_ext, r_avdd, r_dac});
      end
      for (s = 0; s < 8; s++) begin
         wr(asc_pkg::OFS_CTRL_A, 8'h0F);
         wr(asc_pkg::OFS_CTRL_B, {3'(s), 5'h0});
         for (c = (s == 0 || s == 7) ? 0 : 6; c < 16; c++) begin
            wr(asc_pkg::OFS_CTRL_A, {4'h0, 4'(c)});
            ee = ((s == 0 || s == 7) && c <= 5) ? (6'h01 << c) : 6'h00;
            ei = (s >= 1 && s <= 6) ? (6'h01 << (s - 1)) : 6'h00;
            #1 check("external chan", {26'h0, ee}, ext_ch);
            check("internal source", {26'h0, ei}, int_src);
         end
      end
      $display("Test selects done");

      wr(asc_pkg::OFS_PORT_DIR, 8'h3F);
      wr(asc_pkg::OFS_PULL_HIGH, 8'h2D);
      wr(asc_pkg::OFS_PIN_SHARE, 8'h55);
      #1 check("analog pins", 32'h15, p_ana);
      check("digital pins", 32'h2A, p_dig);
      check("dir override", 32'h2A, p_oe);
      check("pull cut", 32'h28, p_pull);
      check("vref pin", 32'h1, vref_en);
      $display("Test pin share done");

      for (k = 0; k < 8; k++) run_conv(3'(k));
      $display("Test conversions done");

      wr(asc_pkg::OFS_CTRL_B, 8'h00);
      wr(asc_pkg::OFS_CTRL_A, 8'hB0);
      repeat (40) @(posedge core_clk);
      check("start high only", 32'h0, samp);
      adc_res <= 12'h3C6;
      wr(asc_pkg::OFS_CTRL_A, 8'h30);
      rd_chk("busy abort run", asc_pkg::OFS_CTRL_A, 32'h70);
      wr(asc_pkg::OFS_CTRL_A, 8'h10);
      #1 check("power off", 32'h0, pwr);
      n_samp = 0;
      n_conv = 0;
      repeat (60) @(posedge core_clk);
      check("idle ticks", 32'h0, {tick, samp, conv, n_samp[0], n_conv[0]});
      rd_chk("no flag", asc_pkg::OFS_IRQ_STAT, 32'h0);
      rd_chk("kept low", asc_pkg::OFS_RES_LOW, 32'hF6);
      rd_chk("kept high", asc_pkg::OFS_RES_HIGH, 32'h4);
      $display("Test power off done");
      finish_test();
   end

   initial begin
      repeat (80000) @(posedge core_clk);
      n_errors++;
      finish_test();
   end
endmodule : asc_top_tb
